// file: pkg/lpc_pkg.sv
// Constants and types shared by the companding unit
package lpc_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_PORT0  = 12'h020;
   localparam logic [11:0] ADDR_PORT7  = 12'h03c;
   localparam logic [2:0]  CODEC_PORT  = 3'h1;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int          CTRL_MODE_LSB = 0;
   localparam int          CTRL_LAW_BIT  = 2;
   localparam int          CTRL_FMT_BIT  = 3;
   localparam logic [3:0]  CTRL_RESET    = 4'h0;
   localparam int          STAT_PEND_BIT = 0;
   localparam int          STAT_TXV_BIT  = 1;
   localparam int          STAT_RXV_BIT  = 2;
   localparam int          STAT_RXR_BIT  = 3;
   // ---------------------------------------------------------------
   // Sample formats
   // ---------------------------------------------------------------
   localparam int          LIN_W       = 16;
   localparam int          LOG_W       = 8;
   localparam int          SIGN_BIT    = 15;
   localparam logic [12:0] MU_BIAS     = 13'h0021;
   localparam logic [12:0] MU_MAX_MAG  = 13'h1fff;
   localparam logic [12:0] A_MAX_MAG   = 13'h0fff;
   localparam logic [7:0]  A_XOR_MASK  = 8'h55;
   localparam int          FIFO_DEPTH  = 32;
   // ---------------------------------------------------------------
   // Operating modes, Gray ordered
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      LPC_SER_ENC = 2'h0,
      LPC_SER_DEC = 2'h1,
      LPC_PAR_DEC = 2'h3,
      LPC_PAR_ENC = 2'h2
   } lpc_mode_t;
endpackage

// file: src/lpc_codec.sv
// Companding unit: receive FIFO and the APB-mapped log/linear codec
// ---------------------------------------------------------------
// Notes on behaviour
// RL1: Four modes: serial encode, serial decode, parallel encode, parallel decode.
// RL2: Converts both ways between 8-bit code and sign-magnitude or two's-complement.
// RL3: Mu-law or A-law chosen by control bit, for encode and decode.
// RL4: Thirteen bits of linear range map onto an 8-bit log code.
// RL5: Serial encode compresses each outgoing sample before transmission.
// RL6: Serial decode expands each incoming sample to linear form.
// RL7: Parallel modes: write to codec port converts with the enabled direction.
// RL8: Parallel encode: write linear sample, later read returns the code.
// RL9: Parallel decode: write log sample, later read returns linear value.
// RL10: Host leaves a cycle between write and read for two's-complement.
// RL11: Second write without read moves first result to transmit holding register.
// RL12: Host does one write then one read per parallel sample.
// RL13: Writes to ports 2 to 7 change nothing.
// RL14: Sign-magnitude has sign in MSB, bits below it zero down to magnitude.
// RL15: Mu-law sign-magnitude extremes are 1FFFh and 9FFFh.
// RL16: A-law sign-magnitude extremes are 0FFFh and 8FFFh.
// RL17: Host biases mu-law sign-magnitude samples by 33 and clamps.
// RL18: Host converts A-law samples to 13-bit sign-magnitude, unbiased, clamped.
// RL19: Parallel result holds until next write to the codec port.
// ---------------------------------------------------------------

// ---------------------------------------------------------------
// Receive FIFO
// ---------------------------------------------------------------
module lpc_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic [AW:0]   next_count;
   logic          push;
   logic          pop;

   assign push     = in_valid & in_ready;
   assign pop      = out_valid & out_ready;
   assign out_data = mem[rd_ptr];

   always_comb begin
      next_count = count;
      if (push & ~pop) begin
         next_count = count + 1'h1;
      end else if (pop & ~push) begin
         next_count = count - 1'h1;
      end
   end

   always_ff @(posedge pclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'h0;
         out_valid <= 1'h0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'h1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'h1;
         end
         count     <= next_count;
         // Flags registered so the ready seen outside is glitch free
         in_ready  <= (next_count != (AW+1)'(DEPTH));
         out_valid <= (next_count != '0);
      end
   end
endmodule // lpc_fifo

// ---------------------------------------------------------------
// Companding unit top
// ---------------------------------------------------------------
module lpc_codec
   import lpc_pkg::*;
#(
   parameter int AW = 12
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [AW-1:0]     paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // Serial transmit side
   output logic [LOG_W-1:0]       serial_transmit_holding_register,
   output logic                   tx_valid,
   input  wire logic              tx_ready,
   // Serial receive side
   input  wire logic [LOG_W-1:0]  rx_code,
   input  wire logic              rx_valid,
   output logic                   rx_ready
);
   // ---------------------------------------------------------------
   // Conversion functions
   // ---------------------------------------------------------------
   function automatic logic [LOG_W-1:0] lpc_encode(input logic [LIN_W-1:0] x,
                                                   input logic a_law,
                                                   input logic twos);
      logic        neg;
      logic [15:0] abs_v;
      logic [12:0] mag;
      logic [2:0]  seg;
      logic [12:0] sh;
      int          top;
      neg   = x[SIGN_BIT];
      abs_v = neg ? 16'(-x) : x;
      mag   = x[12:0];
      top   = 0;
      if (twos) begin // RL2
         if (a_law) begin
            mag = (abs_v > 16'(A_MAX_MAG)) ? A_MAX_MAG : abs_v[12:0];
         end else begin
            // Device-side bias so two's-complement input needs no prework
            mag = (abs_v > 16'(MU_MAX_MAG - MU_BIAS)) ? MU_MAX_MAG // RL15
                                                      : abs_v[12:0] + MU_BIAS;
         end
      end else if (a_law && mag > A_MAX_MAG) begin // RL16
         mag = A_MAX_MAG;
      end
      for (int i = 5; i <= 12; i++) begin // RL4
         if (mag[i]) begin
            top = i;
         end
      end
      if (a_law) begin // RL3
         seg = (top >= 5) ? 3'(top - 4) : 3'h0;
         sh  = mag >> ((seg == 3'h0) ? 3'h1 : seg);
         return {~neg, seg, sh[3:0]} ^ A_XOR_MASK;
      end else begin
         seg = (top >= 5) ? 3'(top - 5) : 3'h0;
         sh  = mag >> (seg + 4'h1);
         return ~{neg, seg, sh[3:0]};
      end
   endfunction

   function automatic logic [LIN_W-1:0] lpc_decode(input logic [LOG_W-1:0] c,
                                                   input logic a_law,
                                                   input logic twos);
      logic [7:0]  t;
      logic        neg;
      logic [15:0] mag;
      t   = a_law ? (c ^ A_XOR_MASK) : ~c;
      neg = a_law ? ~t[7] : t[7];
      if (a_law) begin // RL3
         mag = (t[6:4] == 3'h0) ? {11'h000, t[3:0], 1'h1}
                                : 16'({10'h000, 1'h1, t[3:0], 1'h1} << (t[6:4] - 3'h1));
      end else begin
         // Sign-magnitude mu-law output keeps the bias; host strips it
         mag = 16'({10'h000, 1'h1, t[3:0], 1'h1} << t[6:4]);
      end
      if (twos) begin // RL2
         if (!a_law) begin
            mag = mag - 16'(MU_BIAS);
         end
         return neg ? 16'(-mag) : mag;
      end
      return {neg, 2'h0, mag[12:0]}; // RL14
   endfunction

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic [3:0]        ctrl;
   lpc_mode_t         mode;
   logic              law_a;
   logic              fmt_twos;
   logic [LIN_W-1:0]  result;
   logic              pending;
   logic              setup;
   logic              access;
   logic              wr;
   logic              rd;
   logic              is_port;
   logic [2:0]        port_num;
   logic              wr_p1;
   logic              rd_p1;
   logic              mapped;
   logic [31:0]       rd_mux;
   logic              fifo_out_valid;
   logic [LIN_W-1:0]  fifo_out_data;
   logic              fifo_pop;

   assign mode     = lpc_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
   assign law_a    = ctrl[CTRL_LAW_BIT];
   assign fmt_twos = ctrl[CTRL_FMT_BIT];
   assign setup    = psel & ~penable;
   assign access   = psel & penable & pready;
   assign wr       = access & pwrite;
   assign rd       = access & ~pwrite;
   assign is_port  = (paddr >= AW'(ADDR_PORT0)) && (paddr <= AW'(ADDR_PORT7));
   assign port_num = 3'(paddr[4:2]);
   assign wr_p1    = wr & is_port & (port_num == CODEC_PORT); // RL13
   assign rd_p1    = rd & is_port & (port_num == CODEC_PORT);
   assign fifo_pop = rd_p1 & (mode == LPC_SER_DEC);

   always_comb begin
      rd_mux = 32'h0000_0000;
      mapped = 1'h1;
      if (paddr == AW'(ADDR_CTRL)) begin
         rd_mux = {28'h000_0000, ctrl};
      end else if (paddr == AW'(ADDR_STATUS)) begin
         rd_mux[STAT_PEND_BIT] = pending;
         rd_mux[STAT_TXV_BIT]  = tx_valid;
         rd_mux[STAT_RXV_BIT]  = fifo_out_valid;
         rd_mux[STAT_RXR_BIT]  = rx_ready;
      end else if (is_port && paddr[1:0] == 2'h0) begin
         if (port_num == CODEC_PORT) begin
            rd_mux = {16'h0000, (mode == LPC_SER_DEC) ? fifo_out_data : result};
         end
      end else begin
         mapped = 1'h0;
      end
   end

   // Zero-wait slave: pready rises for the access phase only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'h0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'h0;
      end else begin
         pready  <= setup;
         if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~mapped;
         end
      end
   end

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
      end else if (wr && paddr == AW'(ADDR_CTRL)) begin
         ctrl <= pwdata[3:0]; // RL1
      end
   end

   // ---------------------------------------------------------------
   // Parallel conversion result
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result  <= '0;
         pending <= 1'h0;
      end else if (wr_p1 && mode == LPC_PAR_ENC) begin
         result  <= {8'h00, lpc_encode(pwdata[15:0], law_a, fmt_twos)}; // RL7 RL8
         pending <= 1'h1;
      end else if (wr_p1 && mode == LPC_PAR_DEC) begin
         result  <= lpc_decode(pwdata[7:0], law_a, fmt_twos); // RL7 RL9
         pending <= 1'h1;
      end else if (rd_p1) begin
         // Result itself stays put; only the read marks it consumed
         pending <= 1'h0; // RL19
      end
   end

   // ---------------------------------------------------------------
   // Transmit holding register
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_transmit_holding_register <= '0;
         tx_valid                         <= 1'h0;
      end else if (wr_p1 && mode == LPC_SER_ENC) begin
         serial_transmit_holding_register <= lpc_encode(pwdata[15:0], law_a, fmt_twos); // RL5
         tx_valid                         <= 1'h1;
      end else if (wr_p1 && pending && (mode == LPC_PAR_ENC || mode == LPC_PAR_DEC)) begin
         // Unread result is lost to software once pushed out
         serial_transmit_holding_register <= result[7:0]; // RL11
         tx_valid                         <= 1'h1;
      end else if (tx_ready) begin
         tx_valid <= 1'h0;
      end
   end

   // ---------------------------------------------------------------
   // Receive path through the FIFO
   // ---------------------------------------------------------------
   lpc_fifo #(
      .W     (LIN_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (rx_valid & (mode == LPC_SER_DEC)),
      .in_ready  (rx_ready),
      .in_data   (lpc_decode(rx_code, law_a, fmt_twos)), // RL6
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_par_enc;
      wr_p1 && mode == LPC_PAR_ENC
      |=> result == {8'h00, lpc_encode($past(pwdata[15:0]), law_a, fmt_twos)} && pending;
   endproperty
   a_par_enc: assert property (p_par_enc) else $error("parallel encode result wrong"); // RL8

   property p_par_dec;
      wr_p1 && mode == LPC_PAR_DEC
      |=> result == lpc_decode($past(pwdata[7:0]), law_a, fmt_twos);
   endproperty
   a_par_dec: assert property (p_par_dec) else $error("parallel decode result wrong"); // RL9

   property p_push_out;
      wr_p1 && pending && mode inside {LPC_PAR_ENC, LPC_PAR_DEC}
      |=> tx_valid && serial_transmit_holding_register == $past(result[7:0]);
   endproperty
   a_push_out: assert property (p_push_out) else $error("double write did not push"); // RL11

   property p_other_ports;
      wr && is_port && port_num >= 3'h2
      |=> $stable(result) && $stable(serial_transmit_holding_register) && $stable(pending);
   endproperty
   a_other_ports: assert property (p_other_ports) else $error("port 2-7 write had effect"); // RL13

   property p_hold;
      !wr_p1 |=> $stable(result);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed without write"); // RL19

   property p_ser_enc;
      wr_p1 && mode == LPC_SER_ENC
      |=> tx_valid && serial_transmit_holding_register
          == lpc_encode($past(pwdata[15:0]), law_a, fmt_twos);
   endproperty
   a_ser_enc: assert property (p_ser_enc) else $error("serial encode not loaded"); // RL5

   property p_ser_dec;
      rx_valid && rx_ready && mode == LPC_SER_DEC |=> fifo_out_valid;
   endproperty
   a_ser_dec: assert property (p_ser_dec) else $error("received sample lost"); // RL6

   property p_sm_zero;
      wr_p1 && mode == LPC_PAR_DEC && !fmt_twos |=> result[14:13] == 2'h0;
   endproperty
   a_sm_zero: assert property (p_sm_zero) else $error("sign-magnitude gap not zero"); // RL14

   property p_mu_max;
      wr_p1 && mode == LPC_PAR_ENC && !law_a && !fmt_twos && pwdata[15:0] == 16'h1fff
      |=> result[7:0] == 8'h80;
   endproperty
   a_mu_max: assert property (p_mu_max) else $error("mu-law max code wrong"); // RL15

   property p_a_max;
      wr_p1 && mode == LPC_PAR_ENC && law_a && !fmt_twos && pwdata[15:0] == 16'h8fff
      |=> result[7:0] == 8'h2a;
   endproperty
   a_a_max: assert property (p_a_max) else $error("A-law max code wrong"); // RL16

   c_par_pair: cover property (wr_p1 && mode == LPC_PAR_ENC ##[2:10] rd_p1);
   c_double:   cover property (wr_p1 && pending && mode == LPC_PAR_DEC);
   c_rx_full:  cover property (mode == LPC_SER_DEC && rx_valid && !rx_ready);
   c_ser_tx:   cover property (wr_p1 && mode == LPC_SER_ENC ##1 tx_valid && tx_ready);
endmodule // lpc_codec

// file: testbench/lpc_serial_model.sv
// Serial port model facing the companding unit
module lpc_serial_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Transmit side
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic       tx_hold,
   output logic [7:0]      tx_last,
   // Receive side
   output logic [7:0]      rx_code,
   output logic            rx_valid,
   input  wire logic       rx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // Transmit taker, stalls while held
   // ---------------------------------------------------------------
   initial begin
      rx_code = 8'h00;
      rx_valid = 1'b0;
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ready <= 1'b0;
         tx_last <= 8'h00;
      end else begin
         tx_ready <= !tx_hold;
         if (tx_valid && tx_ready) tx_last <= tx_byte;
      end
   end
   // Offers one code; an idle line shows the inverse so stale data never matches
   task automatic push(input logic [7:0] code, input int bound, output bit took);
      took = 1'b0;
      @(posedge pclk);
      rx_code <= code;
      rx_valid <= 1'b1;
      for (int i = 0; i < bound && !took; i++) begin
         @(posedge pclk);
         took = rx_ready;
      end
      rx_valid <= 1'b0;
      rx_code <= ~code;
   endtask
endmodule // lpc_serial_model

// file: testbench/lpc_codec_bench.sv
// Self-checking bench for the companding unit
module lpc_codec_bench import lpc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   localparam logic [11:0] P1 = ADDR_PORT0 + {7'h00, CODEC_PORT, 2'b00};
   localparam logic [15:0] CORNER [4] = '{16'h7fff, 16'h8000, 16'h0000, 16'hffff};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [7:0]  tx_byte, rx_code, tx_last, c;
   logic [15:0] v, s1;
   logic        tx_valid, tx_ready, rx_valid, rx_ready, tx_hold, e, a, tw;
   logic [7:0]  q [32];
   bit          took;
   int          err_total, tests_run;
   integer      seed;

   lpc_codec #(.AW(12)) u_lpc_codec (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .serial_transmit_holding_register(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_code(rx_code), .rx_valid(rx_valid), .rx_ready(rx_ready));
   lpc_serial_model u_lpc_serial_model (
      .pclk(pclk), .presetn(presetn), .tx_byte(tx_byte), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_hold(tx_hold), .tx_last(tx_last), .rx_code(rx_code),
      .rx_valid(rx_valid), .rx_ready(rx_ready));

   always #25 pclk = ~pclk;
   // ---------------------------------------------------------------
   // Tasks and expectation functions
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("Mismatches %0d, checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic timeout();
      err_total++;
      $display("Error at %0t: wait ran out", $time);
      close_out();
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] dt,
                      output logic [31:0] r, output logic er);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= dt;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) timeout();
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
      logic [31:0] r;
      logic er;
      apb(1'b1, ad, dt, r, er);
   endtask
   task automatic rd(input logic [11:0] ad, output logic [31:0] r);
      logic er;
      apb(1'b0, ad, 32'h0, r, er);
   endtask
   task automatic setm(input lpc_mode_t m);
      wr(ADDR_CTRL, {28'h0, tw, a, m});
   endtask
   task automatic drain_tx();
      tx_hold <= 1'b0;
      for (int i = 0; i < 20 && tx_valid === 1'b1; i++) @(posedge pclk);
      if (tx_valid !== 1'b0) timeout();
   endtask
   // Host side preparation of a sample: magnitude, bias, clamp
   function automatic logic [15:0] prep(logic [15:0] x, logic al);
      int m;
      m = x[15] ? 65536 - x : x;
      m = m + (al ? 0 : 33);
      if (m > (al ? 4095 : 8191)) m = al ? 4095 : 8191;
      return {x[15], 2'b00, 13'(m)};
   endfunction
   function automatic logic [7:0] enc(logic [15:0] sm, logic al);
      int m, g, t;
      m = sm[12:0];
      g = 0;
      while (g < 7 && m >= ((al ? 32 : 64) << g)) g++;
      t = al ? ((g == 0 ? m >> 1 : m >> g) & 15) : ((m >> (g + 1)) & 15);
      return al ? {~sm[15], 3'(g), 4'(t)} ^ A_XOR_MASK : ~{sm[15], 3'(g), 4'(t)};
   endfunction
   function automatic logic [15:0] dec(logic [7:0] cd, logic al, logic t2);
      logic [7:0] x;
      logic s;
      int g, t, m;
      x = al ? cd ^ A_XOR_MASK : ~cd;
      s = al ? ~x[7] : x[7];
      g = x[6:4];
      t = x[3:0];
      m = al ? (g == 0 ? 2 * t + 1 : (2 * t + 33) << (g - 1)) : (2 * t + 33) << g;
      if (!t2) return {s, 2'b00, 13'(m)};
      if (!al) m = m - 33;
      return s ? 16'(-m) : 16'(m);
   endfunction
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'h5c1b_da74;
      {pclk, presetn, psel, penable, pwrite, tx_hold} = 6'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      err_total = 0;
      tests_run = 0;
      repeat (12) @(posedge pclk);
      chk({pready, pslverr, tx_valid, rx_ready}, 32'h0);
      presetn <= 1'b1;
      rd(ADDR_CTRL, d);
      chk(d, {28'h0, CTRL_RESET});
      rd(ADDR_STATUS, d);
      chk(d, 32'h0000_0008);
      apb(1'b0, 12'h100, 32'h0, d, e);
      chk({e, d[30:0]}, 32'h8000_0000);
      // Every law and format, parallel both ways; gap before read covers two's form
      for (int k = 0; k < 4; k++) begin
         {tw, a} = 2'(k);
         for (int i = 0; i < 12; i++) begin
            v = (i < 4) ? CORNER[i] : 16'($random(seed));
            setm(LPC_PAR_ENC);
            wr(P1, {16'h0, tw ? v : prep(v, a)});
            if (i == 0) for (int p = 2; p < 8; p++) wr(ADDR_PORT0 + 12'(4 * p), $random(seed));
            rd(P1, d);
            chk(d[7:0], enc(prep(v, a), a));
            chk({23'h0, tx_valid, tx_last}, 32'h0);
            setm(LPC_PAR_DEC);
            c = v[7:0];
            wr(P1, {24'h0, c});
            rd(P1, d);
            chk(d[15:0], dec(c, a, tw));
            rd(P1, d);
            chk(d[15:0], dec(c, a, tw));
         end
      end
      // Two writes without a read push the first result out
      {tw, a} = 2'b00;
      setm(LPC_PAR_ENC);
      tx_hold <= 1'b1;
      s1 = prep(16'($random(seed)), 1'b0);
      wr(P1, {16'h0, s1});
      wr(P1, {16'h0, 16'h1fff});
      repeat (2) @(posedge pclk);
      chk({tx_valid, tx_byte}, {1'b1, enc(s1, 1'b0)});
      rd(P1, d);
      chk(d[7:0], 8'h80);
      drain_tx();
      chk(tx_last, enc(s1, 1'b0));
      // Serial encode, receive path ignored in this mode
      {tw, a} = 2'b11;
      setm(LPC_SER_ENC);
      u_lpc_serial_model.push(8'h33, 4, took);
      tx_hold <= 1'b1;
      v = 16'($random(seed));
      wr(P1, {16'h0, v});
      repeat (2) @(posedge pclk);
      chk({tx_valid, tx_byte}, {1'b1, enc(prep(v, 1'b1), 1'b1)});
      drain_tx();
      chk(tx_last, enc(prep(v, 1'b1), 1'b1));
      rd(ADDR_STATUS, d);
      chk(d[2], 1'b0);
      // Serial decode: fill until refused, then drain in order
      {tw, a} = 2'b10;
      setm(LPC_SER_DEC);
      for (int i = 0; i < 32; i++) begin
         q[i] = 8'($random(seed));
         u_lpc_serial_model.push(q[i], 20, took);
         chk(took, 1'b1);
      end
      @(posedge pclk);
      u_lpc_serial_model.push(8'h5a, 4, took);
      chk({took, rx_ready}, 2'b00);
      rd(ADDR_STATUS, d);
      chk(d[3:2], 2'b01);
      for (int i = 0; i < 32; i++) begin
         rd(P1, d);
         chk(d[15:0], dec(q[i], a, tw));
      end
      // Empty FIFO shows its stale head slot, wrapped back to the first sample
      rd(P1, d);
      chk(d, {16'h0, dec(q[0], a, tw)});
      rd(ADDR_STATUS, d);
      chk(d[3:2], 2'b10);
      close_out();
   end
endmodule // lpc_codec_bench
